// *** uip_host.sv ***
// host processor model: single-word ahb-lite transfers toward the uart block
`timescale 1ns/100ps
module uip_host (
  // clock
  input wire logic mclk,
  // ahb-lite master side
  output logic hsel,
  output logic [7:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata
);
  initial begin
    hsel = 1'b0;
    haddr = 8'h00;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end
  // entered right after a rising edge; address held until hready seen high
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= uip_pkg::HTRANS_NONSEQ;
    hwrite <= wr;
    @(posedge mclk);
    while (hready !== 1'b1) @(posedge mclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge mclk);
    while (hready !== 1'b1) @(posedge mclk);
    rd = hrdata;
  endtask : xfer
endmodule : uip_host

// *** uip_irq.sv ***
// interrupt enable, priority status and source clearing of one uart channel
`timescale 1ns/100ps
module uip_irq #(
  parameter int ADDR_W = 8,
  parameter int LVL_W = 5
) (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // receive side status from the serial engine
  input wire logic [LVL_W-1:0] rx_level,
  input wire logic [7:0] rx_head_data,
  input wire logic rx_push,
  input wire logic rx_overrun,
  input wire logic [2:0] rx_head_err,
  input wire logic rx_any_err,
  input wire logic bit_tick,
  input wire logic [3:0] char_bits,
  // transmit side status
  input wire logic tx_hold_empty,
  input wire logic tx_shift_empty,
  // modem lines and their change pulses
  input wire logic [3:0] modem_lines,
  input wire logic [3:0] modem_delta,
  // interrupt driver select strap
  input wire logic irq_output_select,
  // strobes toward the serial engine
  output logic rx_pop,
  output logic tx_push,
  output logic [7:0] tx_data,
  output logic fifo_enable,
  output logic rx_fifo_clear,
  output logic tx_fifo_clear,
  // interrupt pin
  output logic irq_out,
  output logic irq_out_oe_n
);
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [4:0] trig_level(input logic [1:0] sel);
    unique case (sel)
      2'h0: trig_level = uip_pkg::TRIG_L0;
      2'h1: trig_level = uip_pkg::TRIG_L1;
      2'h2: trig_level = uip_pkg::TRIG_L2;
      2'h3: trig_level = uip_pkg::TRIG_L3;
    endcase
  endfunction : trig_level

  logic [3:0] mask_reg;
  logic fifo_en_reg;
  logic [1:0] trig_reg;
  logic [4:0] mcr_reg;
  logic ovr_reg, line_pend_reg, tmo_pend_reg, tx_pend_reg;
  logic [3:0] delta_reg;
  logic [2:0] head_err_reg;
  logic thr_empty_reg;
  logic [6:0] tmo_cnt_reg;
  logic [2:0] idx_reg;
  logic act_reg, wr_reg;
  uip_pkg::uip_src_t cur_src_reg, cur_src_next;
  logic [31:0] hrdata_reg;
  logic hreadyout_reg, rx_pop_reg, tx_push_reg, rxclr_reg, txclr_reg;
  logic [7:0] tx_data_reg;
  logic irq_reg, oe_n_reg;

  ////////////////////////////////////////////////////////////////////////////
  // bus decode; every access takes one wait state
  wire take = hsel && hready && htrans == uip_pkg::HTRANS_NONSEQ;
  wire fire = act_reg;
  wire rd_fire = fire && !wr_reg;
  wire wr_fire = fire && wr_reg;
  wire rd_hold = rd_fire && idx_reg == uip_pkg::IDX_HOLD;
  wire rd_stat = rd_fire && idx_reg == uip_pkg::IDX_STAT;
  wire rd_lstat = rd_fire && idx_reg == uip_pkg::IDX_LSTAT;
  wire rd_mstat = rd_fire && idx_reg == uip_pkg::IDX_MSTAT;
  wire wr_hold = wr_fire && idx_reg == uip_pkg::IDX_HOLD;
  wire wr_mask = wr_fire && idx_reg == uip_pkg::IDX_MASK;
  wire wr_fcr = wr_fire && idx_reg == uip_pkg::IDX_STAT && hwdata[uip_pkg::FCR_FIFO_EN];
  wire wr_fcr0 = wr_fire && idx_reg == uip_pkg::IDX_STAT;
  wire wr_mcr = wr_fire && idx_reg == uip_pkg::IDX_MCTL;

  ////////////////////////////////////////////////////////////////////////////
  // source detection
  wire [4:0] trig_now = trig_level(trig_reg);
  wire data_ready = rx_level != '0;
  wire rx_at_trig = fifo_en_reg ? ({{(5 > LVL_W ? 5 - LVL_W : 0){1'b0}}, rx_level} >= trig_now)
                                : data_ready;
  wire [2:0] head_err = data_ready ? rx_head_err : 3'h0;
  wire err_arrive = |(head_err & ~head_err_reg);
  wire line_evt = rx_overrun || err_arrive;
  wire tx_evt = (tx_hold_empty && !thr_empty_reg) ||
                (wr_mask && hwdata[uip_pkg::MASK_TX] && !mask_reg[uip_pkg::MASK_TX] && tx_hold_empty);
  wire [6:0] tmo_limit = {1'b0, char_bits, 2'b00} + uip_pkg::TMO_EXTRA_BITS;
  wire tmo_run = fifo_en_reg && data_ready && !tmo_pend_reg;
  wire tmo_evt = tmo_run && bit_tick && tmo_cnt_reg + 7'h01 >= tmo_limit;
  wire p_line = mask_reg[uip_pkg::MASK_LINE] && line_pend_reg;
  wire p_tmo = mask_reg[uip_pkg::MASK_RX] && tmo_pend_reg;
  wire p_rx = mask_reg[uip_pkg::MASK_RX] && rx_at_trig;
  wire p_tx = mask_reg[uip_pkg::MASK_TX] && tx_pend_reg;
  wire p_modem = mask_reg[uip_pkg::MASK_MODEM] && |delta_reg;
  wire any_pend = p_line || p_tmo || p_rx || p_tx || p_modem;

  function automatic logic src_live(input uip_pkg::uip_src_t s, input logic [4:0] p);
    unique case (s)
      uip_pkg::SRC_NONE: src_live = 1'b0;
      uip_pkg::SRC_LINE: src_live = p[4];
      uip_pkg::SRC_TMO: src_live = p[3];
      uip_pkg::SRC_RX_READY_IRQ: src_live = p[2];
      uip_pkg::SRC_TX_READY_IRQ: src_live = p[1];
      uip_pkg::SRC_MODEM: src_live = p[0];
    endcase
  endfunction : src_live

  wire [4:0] pvec = {p_line, p_tmo, p_rx, p_tx, p_modem};
  wire cur_live = src_live(cur_src_reg, pvec);
  // the reported source stays until it clears; then highest pending wins
  always_comb begin
    if (cur_live) begin
      cur_src_next = cur_src_reg;
    end else if (p_line) begin
      cur_src_next = uip_pkg::SRC_LINE;
    end else if (p_tmo) begin
      cur_src_next = uip_pkg::SRC_TMO;
    end else if (p_rx) begin
      cur_src_next = uip_pkg::SRC_RX_READY_IRQ;
    end else if (p_tx) begin
      cur_src_next = uip_pkg::SRC_TX_READY_IRQ;
    end else if (p_modem) begin
      cur_src_next = uip_pkg::SRC_MODEM;
    end else begin
      cur_src_next = uip_pkg::SRC_NONE;
    end
  end

  wire [3:0] code =
    cur_src_reg == uip_pkg::SRC_LINE ? uip_pkg::CODE_LINE :
    cur_src_reg == uip_pkg::SRC_TMO ? uip_pkg::CODE_TMO :
    cur_src_reg == uip_pkg::SRC_RX_READY_IRQ ? uip_pkg::CODE_RX_READY_IRQ :
    cur_src_reg == uip_pkg::SRC_TX_READY_IRQ ? uip_pkg::CODE_TX_READY_IRQ :
    cur_src_reg == uip_pkg::SRC_MODEM ? uip_pkg::CODE_MODEM : uip_pkg::CODE_NONE;

  ////////////////////////////////////////////////////////////////////////////
  // read data
  wire [7:0] stat_byte = {{2{fifo_en_reg}}, 2'b00, code};
  wire [7:0] lstat_byte = {rx_any_err, tx_hold_empty && tx_shift_empty, tx_hold_empty,
                           head_err, ovr_reg, data_ready};
  wire [7:0] rd_byte =
    idx_reg == uip_pkg::IDX_HOLD ? rx_head_data :
    idx_reg == uip_pkg::IDX_MASK ? {4'h0, mask_reg} :
    idx_reg == uip_pkg::IDX_STAT ? stat_byte :
    idx_reg == uip_pkg::IDX_MCTL ? {3'h0, mcr_reg} :
    idx_reg == uip_pkg::IDX_LSTAT ? lstat_byte :
    idx_reg == uip_pkg::IDX_MSTAT ? {modem_lines, delta_reg} : 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // bus slave
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      act_reg <= 1'b0;
      wr_reg <= 1'b0;
      idx_reg <= 3'h0;
      hreadyout_reg <= 1'b1;
      hrdata_reg <= 32'h0000_0000;
    end else begin
      act_reg <= take;
      if (take) begin
        wr_reg <= hwrite;
        idx_reg <= haddr[ADDR_W-1:2] < (ADDR_W-2)'(8) ? haddr[4:2] : 3'h7;
      end
      hreadyout_reg <= !take;
      if (rd_fire) begin
        hrdata_reg <= {24'h00_0000, rd_byte};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control registers
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      mask_reg <= uip_pkg::MASK_RST;
      fifo_en_reg <= 1'b0;
      trig_reg <= uip_pkg::TRIG_RST;
      mcr_reg <= uip_pkg::MCR_RST;
      tx_data_reg <= 8'h00;
    end else begin
      if (wr_mask) begin
        mask_reg <= hwdata[3:0];
      end
      if (wr_fcr0) begin
        fifo_en_reg <= hwdata[uip_pkg::FCR_FIFO_EN];
      end
      if (wr_fcr) begin
        trig_reg <= hwdata[uip_pkg::FCR_TRIG_LO +: 2];
      end
      if (wr_mcr) begin
        mcr_reg <= hwdata[4:0];
      end
      if (wr_hold) begin
        tx_data_reg <= hwdata[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sticky sources; a setting event wins over a clear in the same cycle
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ovr_reg <= 1'b0;
      line_pend_reg <= 1'b0;
      tmo_pend_reg <= 1'b0;
      tx_pend_reg <= 1'b0;
      delta_reg <= 4'h0;
      head_err_reg <= 3'h0;
      thr_empty_reg <= 1'b0;
      tmo_cnt_reg <= 7'h00;
      cur_src_reg <= uip_pkg::SRC_NONE;
    end else begin
      head_err_reg <= head_err;
      thr_empty_reg <= tx_hold_empty;
      ovr_reg <= rx_overrun || (ovr_reg && !rd_lstat);
      line_pend_reg <= line_evt || (line_pend_reg && !rd_lstat);
      tmo_pend_reg <= tmo_evt || (tmo_pend_reg && !rd_hold && fifo_en_reg);
      tx_pend_reg <= tx_evt || (tx_pend_reg && !wr_hold &&
                     !(rd_stat && cur_src_reg == uip_pkg::SRC_TX_READY_IRQ));
      delta_reg <= modem_delta | (rd_mstat ? 4'h0 : delta_reg);
      if (!tmo_run || rx_push || rd_hold || tmo_evt) begin
        tmo_cnt_reg <= 7'h00;
      end else if (bit_tick) begin
        tmo_cnt_reg <= tmo_cnt_reg + 7'h01;
      end
      cur_src_reg <= cur_src_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // strobes and interrupt pin
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rx_pop_reg <= 1'b0;
      tx_push_reg <= 1'b0;
      rxclr_reg <= 1'b0;
      txclr_reg <= 1'b0;
      irq_reg <= 1'b0;
      oe_n_reg <= 1'b1;
    end else begin
      rx_pop_reg <= rd_hold;
      tx_push_reg <= wr_hold;
      rxclr_reg <= wr_fcr && hwdata[1];
      txclr_reg <= wr_fcr && hwdata[2];
      irq_reg <= any_pend;
      oe_n_reg <= !(mcr_reg[uip_pkg::MCR_IRQ_EN] || irq_output_select);
    end
  end

  assign hrdata = hrdata_reg;
  assign hreadyout = hreadyout_reg;
  assign hresp = uip_pkg::HRESP_OKAY;
  assign rx_pop = rx_pop_reg;
  assign tx_push = tx_push_reg;
  assign tx_data = tx_data_reg;
  assign fifo_enable = fifo_en_reg;
  assign rx_fifo_clear = rxclr_reg;
  assign tx_fifo_clear = txclr_reg;
  assign irq_out = irq_reg;
  assign irq_out_oe_n = oe_n_reg;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  irq_level_a: assert property (@(posedge mclk) disable iff (!resetn)
    any_pend ##1 any_pend |-> irq_out) else $error("irq output not following pending");
  irq_drive_a: assert property (@(posedge mclk) disable iff (!resetn)
    irq_output_select ##1 irq_output_select |-> !irq_out_oe_n) else $error("irq driver off");
  stat_fifo_a: assert property (@(posedge mclk) disable iff (!resetn)
    rd_stat |=> hrdata[7:4] == {{2{$past(fifo_en_reg)}}, 2'b00}) else $error("fifo bits wrong");
  stat_none_a: assert property (@(posedge mclk) disable iff (!resetn)
    rd_stat && cur_src_reg == uip_pkg::SRC_NONE |=> hrdata[3:0] == 4'h1) else $error("none code wrong");
  line_clear_a: assert property (@(posedge mclk) disable iff (!resetn)
    rd_lstat && !line_evt |=> !line_pend_reg) else $error("line irq not cleared");
  tmo_clear_a: assert property (@(posedge mclk) disable iff (!resetn)
    rd_hold && !tmo_evt |=> !tmo_pend_reg) else $error("time-out not cleared");
  tx_clear_a: assert property (@(posedge mclk) disable iff (!resetn)
    wr_hold && !tx_evt |=> !tx_pend_reg) else $error("tx ready not cleared");
  modem_clear_a: assert property (@(posedge mclk) disable iff (!resetn)
    rd_mstat && modem_delta == 4'h0 |=> delta_reg == 4'h0) else $error("modem irq not cleared");
  rx_trig_a: assert property (@(posedge mclk) disable iff (!resetn)
    fifo_en_reg && mask_reg[0] && rx_level >= trig_now |-> p_rx) else $error("rx trigger missed");
  src_hold_a: assert property (@(posedge mclk) disable iff (!resetn)
    cur_live |=> cur_src_reg == $past(cur_src_reg)) else $error("source preempted");
  line_prio_a: assert property (@(posedge mclk) disable iff (!resetn)
    p_line && !cur_live |=> cur_src_reg == uip_pkg::SRC_LINE) else $error("line source not first");
  line_code_a: assert property (@(posedge mclk) disable iff (!resetn)
    rd_stat && cur_src_reg == uip_pkg::SRC_LINE |=> hrdata[3:0] == 4'h6) else $error("line code wrong");
  tmo_code_a: assert property (@(posedge mclk) disable iff (!resetn)
    rd_stat && cur_src_reg == uip_pkg::SRC_TMO |=> hrdata[3:0] == 4'hC) else $error("time-out code wrong");
  stat_pend_a: assert property (@(posedge mclk) disable iff (!resetn)
    cur_src_reg != uip_pkg::SRC_NONE |-> !code[0]) else $error("pending bit wrong");
  tx_enable_a: assert property (@(posedge mclk) disable iff (!resetn)
    wr_mask && hwdata[uip_pkg::MASK_TX] && !mask_reg[uip_pkg::MASK_TX] && tx_hold_empty |=> tx_pend_reg)
    else $error("tx enable while empty missed");
  ready_flag_a: assert property (@(posedge mclk) disable iff (!resetn)
    rd_lstat |=> hrdata[0] == (|$past(rx_level))) else $error("data ready flag wrong");
  trig_drop_a: assert property (@(posedge mclk) disable iff (!resetn)
    fifo_en_reg && rx_level < trig_now |-> !p_rx) else $error("rx irq held below trigger");
  rx_gate_a: assert property (@(posedge mclk) disable iff (!resetn)
    !mask_reg[uip_pkg::MASK_RX] |-> !p_rx && !p_tmo) else $error("rx irq not masked");
  modem_set_a: assert property (@(posedge mclk) disable iff (!resetn)
    |modem_delta |=> |delta_reg) else $error("modem delta lost");
  irq_clear_a: assert property (@(posedge mclk) disable iff (!resetn)
    !any_pend |=> !irq_out) else $error("irq output stuck");
endmodule : uip_irq

// *** uip_irq_tb.sv ***
// self-checking bench for the uart interrupt enable and priority block
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin samples_checked++; if ((got) !== (exp)) begin error_cnt++; \
  $display("Error %s expected %h seen %h", nm, exp, got); end end
module uip_irq_tb;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic hsel, hwrite, hreadyout, hresp, rx_pop, tx_push, fifo_enable, irq_out, irq_out_oe_n;
  logic rx_fifo_clear, tx_fifo_clear;
  logic [7:0] haddr, tx_data;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, rdv;
  logic [4:0] rx_level = 5'h00;
  logic [7:0] rx_head_data = 8'hA5;
  logic rx_push = 1'b0, rx_overrun = 1'b0, rx_any_err = 1'b0, bit_tick = 1'b0, tick_en = 1'b0;
  logic [2:0] rx_head_err = 3'h0;
  logic [3:0] char_bits = 4'hA, modem_lines = 4'h0, modem_delta = 4'h0;
  logic tx_hold_empty = 1'b0, tx_shift_empty = 1'b0, irq_output_select = 1'b0;
  logic [4:0] trig_lv [4] = '{5'h01, 5'h04, 5'h08, 5'h0E};
  int error_cnt = 0, samples_checked = 0, cycles = 0, pops = 0, pushes = 0, clears = 0;
  logic [7:0] last_tx;
  always #2 mclk = ~mclk;
  uip_host uip_host_i (.mclk(mclk), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata));
  uip_irq uip_irq_i (.mclk(mclk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .rx_level(rx_level), .rx_head_data(rx_head_data),
    .rx_push(rx_push), .rx_overrun(rx_overrun), .rx_head_err(rx_head_err), .rx_any_err(rx_any_err),
    .bit_tick(bit_tick), .char_bits(char_bits), .tx_hold_empty(tx_hold_empty),
    .tx_shift_empty(tx_shift_empty), .modem_lines(modem_lines), .modem_delta(modem_delta),
    .irq_output_select(irq_output_select), .rx_pop(rx_pop), .tx_push(tx_push), .tx_data(tx_data),
    .fifo_enable(fifo_enable), .rx_fifo_clear(rx_fifo_clear), .tx_fifo_clear(tx_fifo_clear),
    .irq_out(irq_out), .irq_out_oe_n(irq_out_oe_n));
  ////////////////////////////////////////////////////////////////////////////
  // bit time every second cycle, strobe watchers, hang guard
  always @(posedge mclk) begin
    bit_tick <= tick_en & ~bit_tick;
    if (rx_pop === 1'b1) pops++;
    if (rx_fifo_clear === 1'b1 && tx_fifo_clear === 1'b1) clears++;
    if (tx_push === 1'b1) begin
      pushes++;
      last_tx = tx_data;
    end
  end
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      $display("Error timeout expected %h seen %h", 1'b0, 1'b1);
      summarize();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] ra(input logic [2:0] idx);
    return {3'h0, idx, 2'h0};
  endfunction : ra
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    uip_host_i.xfer(1'b1, a, d, rdv);
  endtask : wr
  task automatic chk_rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
    uip_host_i.xfer(1'b0, a, 32'h0, rdv);
    `CHK(nm, exp, rdv)
  endtask : chk_rd
  task automatic settle;
    repeat (4) @(posedge mclk);
  endtask : settle
  task automatic summarize;
    $display("Checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : summarize
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge mclk);
    resetn <= 1'b1;
    settle();
    `CHK("irq_oe_n", 1'b1, irq_out_oe_n)
    chk_rd(ra(uip_pkg::IDX_STAT), 32'h01, "status");
    chk_rd(ra(uip_pkg::IDX_MASK), 32'h00, "mask");
    chk_rd(8'h20, 32'h00, "unmapped");
    // polled mode: fifo on, all enables off, flags visible in line status
    wr(ra(uip_pkg::IDX_STAT), 32'h07);
    rx_level <= 5'h03;
    rx_head_err <= 3'h5;
    rx_any_err <= 1'b1;
    tx_hold_empty <= 1'b1;
    settle();
    chk_rd(ra(uip_pkg::IDX_LSTAT), 32'hB5, "line_status");
    chk_rd(ra(uip_pkg::IDX_STAT), 32'hC1, "status");
    `CHK("fifo_enable", 1'b1, fifo_enable)
    `CHK("fifo_clears", 1, clears)
    `CHK("hresp", 1'b0, hresp)
    `CHK("irq_out", 1'b0, irq_out)
    rx_level <= 5'h00;
    rx_head_err <= 3'h0;
    rx_any_err <= 1'b0;
    tx_shift_empty <= 1'b1;
    settle();
    chk_rd(ra(uip_pkg::IDX_LSTAT), 32'h60, "line_status");
    // every trigger code, one below and at the level
    wr(ra(uip_pkg::IDX_MASK), 32'h01);
    for (int k = 0; k < 4; k++) begin
      wr(ra(uip_pkg::IDX_STAT), {24'h0, k[1:0], 6'h01});
      rx_level <= trig_lv[k] - 5'h01;
      settle();
      chk_rd(ra(uip_pkg::IDX_STAT), 32'hC1, "status");
      rx_level <= trig_lv[k];
      settle();
      chk_rd(ra(uip_pkg::IDX_STAT), 32'hC4, "status");
      `CHK("irq_out", 1'b1, irq_out)
      rx_level <= trig_lv[k] - 5'h01;
      settle();
      chk_rd(ra(uip_pkg::IDX_STAT), 32'hC1, "status");
    end
    // line status and data ready both pending, then no preemption
    wr(ra(uip_pkg::IDX_MASK), 32'h05);
    rx_overrun <= 1'b1;
    @(posedge mclk);
    rx_overrun <= 1'b0;
    rx_level <= 5'h0E;
    settle();
    chk_rd(ra(uip_pkg::IDX_STAT), 32'hC6, "status");
    chk_rd(ra(uip_pkg::IDX_LSTAT), 32'h63, "line_status");
    chk_rd(ra(uip_pkg::IDX_STAT), 32'hC4, "status");
    rx_overrun <= 1'b1;
    @(posedge mclk);
    rx_overrun <= 1'b0;
    settle();
    chk_rd(ra(uip_pkg::IDX_STAT), 32'hC4, "status");
    rx_level <= 5'h0D;
    settle();
    chk_rd(ra(uip_pkg::IDX_STAT), 32'hC6, "status");
    chk_rd(ra(uip_pkg::IDX_LSTAT), 32'h63, "line_status");
    chk_rd(ra(uip_pkg::IDX_STAT), 32'hC1, "status");
    // receive time-out: 4 x 10 + 12 = 52 bit times
    wr(ra(uip_pkg::IDX_MASK), 32'h01);
    rx_level <= 5'h01;
    rx_push <= 1'b1;
    tick_en <= 1'b1;
    @(posedge mclk);
    rx_push <= 1'b0;
    repeat (90) @(posedge mclk);
    chk_rd(ra(uip_pkg::IDX_STAT), 32'hC1, "status");
    repeat (24) @(posedge mclk);
    chk_rd(ra(uip_pkg::IDX_STAT), 32'hCC, "status");
    chk_rd(ra(uip_pkg::IDX_HOLD), 32'hA5, "holding");
    tick_en <= 1'b0;
    settle();
    chk_rd(ra(uip_pkg::IDX_STAT), 32'hC1, "status");
    `CHK("pops", 1, pops)
    // transmit ready: enable while empty, status read and holding write clears
    wr(ra(uip_pkg::IDX_HOLD), 32'h11);
    wr(ra(uip_pkg::IDX_MASK), 32'h02);
    settle();
    chk_rd(ra(uip_pkg::IDX_STAT), 32'hC2, "status");
    chk_rd(ra(uip_pkg::IDX_STAT), 32'hC1, "status");
    tx_hold_empty <= 1'b0;
    settle();
    tx_hold_empty <= 1'b1;
    settle();
    chk_rd(ra(uip_pkg::IDX_MASK), 32'h02, "mask");
    `CHK("irq_out", 1'b1, irq_out)
    wr(ra(uip_pkg::IDX_HOLD), 32'h3C);
    settle();
    chk_rd(ra(uip_pkg::IDX_STAT), 32'hC1, "status");
    `CHK("tx_data", 8'h3C, last_tx)
    `CHK("pushes", 2, pushes)
    // modem status and the interrupt driver enable
    wr(ra(uip_pkg::IDX_MASK), 32'h08);
    modem_lines <= 4'h5;
    modem_delta <= 4'h2;
    @(posedge mclk);
    modem_delta <= 4'h0;
    settle();
    chk_rd(ra(uip_pkg::IDX_STAT), 32'hC0, "status");
    `CHK("irq_out", 1'b1, irq_out)
    `CHK("irq_oe_n", 1'b1, irq_out_oe_n)
    wr(ra(uip_pkg::IDX_MCTL), 32'h08);
    settle();
    `CHK("irq_oe_n", 1'b0, irq_out_oe_n)
    chk_rd(ra(uip_pkg::IDX_MSTAT), 32'h52, "modem_status");
    settle();
    chk_rd(ra(uip_pkg::IDX_STAT), 32'hC1, "status");
    `CHK("irq_out", 1'b0, irq_out)
    wr(ra(uip_pkg::IDX_MCTL), 32'h00);
    irq_output_select <= 1'b1;
    settle();
    `CHK("irq_oe_n", 1'b0, irq_out_oe_n)
    irq_output_select <= 1'b0;
    wr(ra(uip_pkg::IDX_STAT), 32'h00);
    settle();
    `CHK("irq_oe_n", 1'b1, irq_out_oe_n)
    chk_rd(ra(uip_pkg::IDX_STAT), 32'h01, "status");
    // non-fifo mode: one held character raises receive data ready
    wr(ra(uip_pkg::IDX_MASK), 32'h01);
    settle();
    chk_rd(ra(uip_pkg::IDX_STAT), 32'h04, "status");
    `CHK("irq_out", 1'b1, irq_out)
    summarize();
  end
endmodule : uip_irq_tb

// *** uip_pkg.sv ***
// constants and types for the uart interrupt enable and priority block
package uip_pkg;
  // register indices, byte address is four times the index
  localparam logic [2:0] IDX_HOLD = 3'h0;
  localparam logic [2:0] IDX_MASK = 3'h1;
  localparam logic [2:0] IDX_STAT = 3'h2;
  localparam logic [2:0] IDX_MCTL = 3'h4;
  localparam logic [2:0] IDX_LSTAT = 3'h5;
  localparam logic [2:0] IDX_MSTAT = 3'h6;
  // field positions
  localparam int MASK_RX = 0;
  localparam int MASK_TX = 1;
  localparam int MASK_LINE = 2;
  localparam int MASK_MODEM = 3;
  localparam int FCR_FIFO_EN = 0;
  localparam int FCR_TRIG_LO = 6;
  localparam int MCR_IRQ_EN = 3;
  // reset values
  localparam logic [3:0] MASK_RST = 4'h0;
  localparam logic [1:0] TRIG_RST = 2'h0;
  localparam logic [4:0] MCR_RST = 5'h00;
  // receive trigger levels
  localparam logic [4:0] TRIG_L0 = 5'h01;
  localparam logic [4:0] TRIG_L1 = 5'h04;
  localparam logic [4:0] TRIG_L2 = 5'h08;
  localparam logic [4:0] TRIG_L3 = 5'h0E;
  // receive time-out span: four characters plus this many bit times
  localparam logic [6:0] TMO_EXTRA_BITS = 7'h0C;
  // status codes in bits 3:0
  localparam logic [3:0] CODE_LINE = 4'h6;
  localparam logic [3:0] CODE_TMO = 4'hC;
  localparam logic [3:0] CODE_RX_READY_IRQ = 4'h4;
  localparam logic [3:0] CODE_TX_READY_IRQ = 4'h2;
  localparam logic [3:0] CODE_MODEM = 4'h0;
  localparam logic [3:0] CODE_NONE = 4'h1;
  // ahb-lite
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'b0;
  typedef enum {SRC_NONE, SRC_LINE, SRC_TMO, SRC_RX_READY_IRQ, SRC_TX_READY_IRQ, SRC_MODEM} uip_src_t;
endpackage : uip_pkg
